/* File: design/lpd_entry_decode.sv */
// Purpose: Decodes large page directory and 64KB leaf entries
// Assumes: Requester holds req stable only for its valid cycle
// Notes: One request per cycle, answer one cycle later, registered
`timescale 1ns/1ps
// Function
// - Large directory page base is entry bits host width minus one to 21.
// - With two-stage translation on, the address is a guest physical one.
// - Host width is 39 for client and 46 for server builds.
// - Large directory entry ignores high bits, 20:10, 8, 6:5 and 2.
// - Null page read makes no memory access, returns zeros, null completion.
// - Writes to a null page are dropped silently.
// - Bits 7, 4, 3 select memory type for coherent requesters.
// - Writable bit clear denies user writes.
// - Writable clear with supervisor protect also denies supervisor writes.
// - 64KB leaf page base is entry bits host width minus one to 16.
// - 64KB leaf entry ignores high bits, 15:10, 8, 6:5 and 2.
// - Table pointer gives 4KB-aligned address from host width minus one to 12.
module lpd_entry_decode #(
    parameter int HOST_W = lpd_pkg::HOST_W_CLIENT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input lpd_pkg::lpd_req_s req,
    input wire logic [lpd_pkg::ENTRY_W-1:0] entry,
    output logic resp_valid,
    output lpd_pkg::lpd_resp_s resp
);

    logic [lpd_pkg::HOST_W_MAX-1:0] base;
    logic [4:0] base_shift;
    logic present;
    logic writable;
    logic null_page;
    logic [2:0] attr_index;

    lpd_field_extract #(
        .HOST_W(HOST_W)
    ) u_extract (
        .entry(entry),
        .kind(req.kind),
        .base(base),
        .base_shift(base_shift),
        .present(present),
        .writable(writable),
        .null_page(null_page),
        .attr_index(attr_index)
    );

    // Offset bits pass below the page size and base bits above it; the
    // extractor has already cleared the base below the page size
    wire [lpd_pkg::HOST_W_MAX-1:0] joined;

    for (genvar i = 0; i < lpd_pkg::HOST_W_MAX; i++)
    begin : g_join
        wire below_page = i < base_shift;
        assign joined[i] = below_page ? req.in_addr[i] : base[i];
    end

    wire is_table = req.kind == lpd_pkg::LPD_KIND_DIR_TABLE;
    // Table pointer must stay 4KB aligned, no offset joined
    wire [lpd_pkg::HOST_W_MAX-1:0] final_addr =
        is_table ? base : joined;

    // Supervisor writes are only checked under protect; contexts of that
    // kind are not expected, so this path is a safety net
    wire write_denied = req.is_write && !writable &&
        (!req.is_super || req.supervisor_write_protect_en);
    wire fault = !present;
    wire is_null = present && null_page;
    wire granted = present && !null_page && !write_denied;
    // Attribute bits of a table pointer are ignored bits, never passed on
    wire attr_on = req.coherent_domain && !is_table;

    lpd_pkg::lpd_result_e result_d;

    always_comb
    begin
        if (fault)
        begin
            result_d = lpd_pkg::LPD_RES_FAULT;
        end
        else if (is_null)
        begin
            // Null page: no access; read gives zeros, write is dropped
            result_d = lpd_pkg::LPD_RES_NULL;
        end
        else if (write_denied)
        begin
            result_d = lpd_pkg::LPD_RES_DENIED;
        end
        else
        begin
            result_d = lpd_pkg::LPD_RES_OK;
        end
    end

    // Refused requests leave every field but the result at zero
    wire mem_access_d = granted;
    wire guest_d = granted && req.two_stage_translation_on;
    wire attr_valid_d = granted && attr_on;
    wire [2:0] attr_index_d = attr_valid_d ? attr_index : 3'h0;
    wire [lpd_pkg::HOST_W_MAX-1:0] out_addr_d =
        granted ? final_addr : lpd_pkg::ADDR_ZERO;

    logic valid_q;
    lpd_pkg::lpd_result_e result_q;
    logic mem_access_q;
    logic guest_q;
    logic attr_valid_q;
    logic [2:0] attr_index_q;
    logic [lpd_pkg::HOST_W_MAX-1:0] out_addr_q;
    logic [lpd_pkg::ENTRY_W-1:0] read_data_q;

    // Answer strobe follows every request by one cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            valid_q <= 1'b0;
        end
        else
        begin
            valid_q <= req_valid;
        end
    end

    // Answer fields hold until the next taken request
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            result_q <= lpd_pkg::LPD_RES_OK;
        end
        else if (req_valid)
        begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mem_access_q <= 1'b0;
        end
        else if (req_valid)
        begin
            mem_access_q <= mem_access_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            guest_q <= 1'b0;
        end
        else if (req_valid)
        begin
            guest_q <= guest_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            attr_valid_q <= 1'b0;
        end
        else if (req_valid)
        begin
            attr_valid_q <= attr_valid_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            attr_index_q <= 3'h0;
        end
        else if (req_valid)
        begin
            attr_index_q <= attr_index_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            out_addr_q <= lpd_pkg::ADDR_ZERO;
        end
        else if (req_valid)
        begin
            out_addr_q <= out_addr_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            read_data_q <= lpd_pkg::DATA_ZERO;
        end
        else if (req_valid)
        begin
            read_data_q <= lpd_pkg::DATA_ZERO;
        end
    end

    assign resp_valid = valid_q;
    assign resp = '{
        result: result_q,
        mem_access: mem_access_q,
        guest_physical_location: guest_q,
        attr_valid: attr_valid_q,
        attr_index: attr_index_q,
        out_addr: out_addr_q,
        read_data: read_data_q
    };

endmodule : lpd_entry_decode

/* File: design/lpd_pkg.sv */
// Purpose: Shared constants and carriers for the large page entry decoder
// Assumes: 64-bit entries, host width 39 (client) or 46 (server)
// Notes: Entry field positions and page sizes of the design live only here; the bench repeats them
package lpd_pkg;

    localparam int ENTRY_W = 64;
    localparam int HOST_W_CLIENT = 39;
    localparam int HOST_W_SERVER = 46;
    localparam int HOST_W_MAX = 46;
    localparam int LARGE_SHIFT = 21;
    localparam int MID_SHIFT = 16;
    localparam int TABLE_SHIFT = 12;
    localparam int BIT_PRESENT = 0;
    localparam int BIT_WRITABLE = 1;
    localparam int BIT_WR_THROUGH = 3;
    localparam int BIT_CACHE_DIS = 4;
    localparam int BIT_LARGE = 7;
    localparam int BIT_ATTR = 7;
    localparam int BIT_NULL = 9;
    localparam logic [HOST_W_MAX-1:0] ADDR_ZERO = '0;
    localparam logic [ENTRY_W-1:0] DATA_ZERO = '0;

    typedef enum logic [1:0] {
        LPD_KIND_DIR_LARGE = 2'h0,
        LPD_KIND_DIR_TABLE = 2'h1,
        LPD_KIND_LEAF_MID = 2'h2
    } lpd_kind_e;

    typedef enum logic [1:0] {
        LPD_RES_OK = 2'h0,
        LPD_RES_NULL = 2'h1,
        LPD_RES_FAULT = 2'h2,
        LPD_RES_DENIED = 2'h3
    } lpd_result_e;

    typedef struct packed {
        logic is_write;
        logic is_super;
        logic two_stage_translation_on;
        logic supervisor_write_protect_en;
        logic coherent_domain;
        lpd_kind_e kind;
        logic [HOST_W_MAX-1:0] in_addr;
    } lpd_req_s;

    typedef struct packed {
        lpd_result_e result;
        logic mem_access;
        logic guest_physical_location;
        logic attr_valid;
        logic [2:0] attr_index;
        logic [HOST_W_MAX-1:0] out_addr;
        logic [ENTRY_W-1:0] read_data;
    } lpd_resp_s;

endpackage : lpd_pkg

/* File: design/lpd_field_extract.sv */
// Purpose: Pulls address and control fields out of one entry word
// Assumes: Entry arrives as one 64-bit little-endian word
// Notes: Purely combinational; bits outside the named fields are dropped
`timescale 1ns/1ps
module lpd_field_extract #(
    parameter int HOST_W = lpd_pkg::HOST_W_CLIENT
) (
    input wire logic [lpd_pkg::ENTRY_W-1:0] entry,
    input lpd_pkg::lpd_kind_e kind,
    output logic [lpd_pkg::HOST_W_MAX-1:0] base,
    output logic [4:0] base_shift,
    output logic present,
    output logic writable,
    output logic null_page,
    output logic [2:0] attr_index
);

    function automatic logic [lpd_pkg::HOST_W_MAX-1:0] mask_from(
        input logic [lpd_pkg::ENTRY_W-1:0] e,
        input int lo
    );
        logic [lpd_pkg::HOST_W_MAX-1:0] m;
        m = '0;
        for (int i = 0; i < lpd_pkg::HOST_W_MAX; i++)
        begin
            if (i >= lo && i < HOST_W)
                m[i] = e[i];
        end
        return m;
    endfunction : mask_from

    // Bits at or above host width never reach the address
    wire [lpd_pkg::HOST_W_MAX-1:0] base_large =
        mask_from(entry, lpd_pkg::LARGE_SHIFT);
    wire [lpd_pkg::HOST_W_MAX-1:0] base_mid =
        mask_from(entry, lpd_pkg::MID_SHIFT);
    wire [lpd_pkg::HOST_W_MAX-1:0] base_table =
        mask_from(entry, lpd_pkg::TABLE_SHIFT);

    assign base = (kind == lpd_pkg::LPD_KIND_DIR_LARGE) ? base_large :
        (kind == lpd_pkg::LPD_KIND_LEAF_MID) ? base_mid : base_table;
    assign base_shift = (kind == lpd_pkg::LPD_KIND_DIR_LARGE) ?
        5'(lpd_pkg::LARGE_SHIFT) :
        (kind == lpd_pkg::LPD_KIND_LEAF_MID) ? 5'(lpd_pkg::MID_SHIFT) :
        5'(lpd_pkg::TABLE_SHIFT);
    assign present = entry[lpd_pkg::BIT_PRESENT];
    assign writable = entry[lpd_pkg::BIT_WRITABLE];
    // Table pointers carry no null or attribute bits
    assign null_page = (kind != lpd_pkg::LPD_KIND_DIR_TABLE) &&
        entry[lpd_pkg::BIT_NULL];
    assign attr_index = {entry[lpd_pkg::BIT_ATTR],
        entry[lpd_pkg::BIT_CACHE_DIS],
        entry[lpd_pkg::BIT_WR_THROUGH]};

endmodule : lpd_field_extract

/* File: testbench/lpd_mem_model.sv */
// Purpose: Table memory slot read by the decoder
// Assumes: Bench loads a word one cycle ahead
// Notes: One slot only
`timescale 1ns/1ps
module lpd_mem_model (
    input wire logic clock,
    input wire logic load,
    input wire logic [63:0] word,
    output logic [63:0] entry
);
    always_ff @(posedge clock)
    begin
        if (load)
            entry <= word;
    end
endmodule : lpd_mem_model

/* File: testbench/lpd_checker.sv */
// Purpose: Port checks of the decoder
// Assumes: Answer one cycle after each request
// Notes: Address checks on grants only
`timescale 1ns/1ps
module lpd_checker #(parameter int HOST_W = 39) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input lpd_pkg::lpd_req_s req,
    input wire logic [63:0] entry,
    input wire logic resp_valid,
    input lpd_pkg::lpd_resp_s resp
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        req_valid && entry[0] && !entry[9];
    endsequence
    sequence s_grant;
        s_take ##0 !(req.is_write && !entry[1] &&
            (!req.is_super || req.supervisor_write_protect_en));
    endsequence
    a_resp_follows: assert property (req_valid |=> resp_valid)
        else $error("no answer");
    a_fault_absent: assert property (req_valid && !entry[0] |=>
        resp.result == lpd_pkg::LPD_RES_FAULT && !resp.mem_access)
        else $error("no fault");
    a_null_zero: assert property (
        req_valid && entry[0] && entry[9] &&
        req.kind != lpd_pkg::LPD_KIND_DIR_TABLE |=> !resp.mem_access &&
        resp.result == lpd_pkg::LPD_RES_NULL && resp.read_data == '0)
        else $error("bad null");
    a_write_deny: assert property (s_take ##0 req.is_write &&
        !entry[1] && (!req.is_super || req.supervisor_write_protect_en)
        |=> resp.result == lpd_pkg::LPD_RES_DENIED) else $error("no deny");
    a_large_addr: assert property (s_grant ##0 req.kind == 2'h0 |=>
        resp.out_addr[HOST_W-1:21] == $past(entry[HOST_W-1:21]) &&
        resp.out_addr[20:0] == $past(req.in_addr[20:0])) else $error("2M");
    a_leaf_addr: assert property (s_grant ##0 req.kind == 2'h2 |=>
        resp.out_addr[HOST_W-1:16] == $past(entry[HOST_W-1:16]) &&
        resp.out_addr[15:0] == $past(req.in_addr[15:0])) else $error("64K");
    a_table_addr: assert property (s_grant ##0 req.kind == 2'h1 |=>
        resp.out_addr[HOST_W-1:12] == $past(entry[HOST_W-1:12]) &&
        resp.out_addr[11:0] == '0) else $error("table");
    a_guest_flag: assert property (s_grant |=> resp.mem_access &&
        resp.guest_physical_location == $past(req.two_stage_translation_on))
        else $error("guest");
    a_attr_pass: assert property (
        s_grant ##0 req.coherent_domain && req.kind != 2'h1
        |=> resp.attr_valid &&
        resp.attr_index == $past({entry[7], entry[4], entry[3]}))
        else $error("attr");
    a_attr_gate: assert property (
        req_valid && !(req.coherent_domain && req.kind != 2'h1)
        |=> !resp.attr_valid && resp.attr_index == 3'h0)
        else $error("attr gate");
endmodule : lpd_checker
bind lpd_entry_decode lpd_checker #(.HOST_W(HOST_W)) u_lpd_checker (
    .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .entry(entry), .resp_valid(resp_valid), .resp(resp));

/* File: testbench/tb_top.sv */
// Purpose: Random requests with corner cases against the decoder
// Assumes: Client and server host widths
// Notes: Refused answers must leave all fields but the result at zero
`timescale 1ns/1ps
module tb_top;
    localparam int HW = 39;
    logic clock = 0, rst_n = 0, req_valid = 0, load = 0, resp_valid;
    logic resp_valid_w;
    logic [63:0] word = '0, entry;
    logic [127:0] rnd;
    lpd_pkg::lpd_req_s req = '0;
    lpd_pkg::lpd_resp_s resp, ex, resp_w, ex_w;
    int n_mismatch = 0, samples_checked = 0, seed = 34889;
    always #20 clock = ~clock;
    lpd_mem_model u_lpd_mem_model (.clock(clock), .load(load),
        .word(word), .entry(entry));
    lpd_entry_decode #(.HOST_W(HW)) u_lpd_entry_decode (.clock(clock),
        .rst_n(rst_n), .req_valid(req_valid), .req(req), .entry(entry),
        .resp_valid(resp_valid), .resp(resp));
    lpd_entry_decode #(.HOST_W(lpd_pkg::HOST_W_SERVER))
        u_lpd_entry_decode_w (.clock(clock), .rst_n(rst_n),
        .req_valid(req_valid), .req(req), .entry(entry),
        .resp_valid(resp_valid_w), .resp(resp_w));
    function automatic lpd_pkg::lpd_resp_s exp_f(lpd_pkg::lpd_req_s r,
        logic [63:0] e, int hw);
        lpd_pkg::lpd_resp_s x;
        lpd_pkg::lpd_result_e rs;
        int sh;
        x = '0;
        sh = r.kind == 0 ? 21 : r.kind == 2 ? 16 : 12;
        for (int i = 0; i < hw; i++)
            x.out_addr[i] = i >= sh ? e[i] : (r.kind != 1 && r.in_addr[i]);
        x.guest_physical_location = r.two_stage_translation_on;
        x.attr_valid = r.coherent_domain && r.kind != 1;
        if (x.attr_valid)
            x.attr_index = {e[7], e[4], e[3]};
        x.mem_access = e[0] && (!e[9] || r.kind == 1);
        if (!e[0])
            x.result = lpd_pkg::LPD_RES_FAULT;
        else if (!x.mem_access)
            x.result = lpd_pkg::LPD_RES_NULL;
        else if (r.is_write && !e[1] &&
            (!r.is_super || r.supervisor_write_protect_en))
            x.result = lpd_pkg::LPD_RES_DENIED;
        if (x.result != lpd_pkg::LPD_RES_OK)
        begin
            rs = x.result;
            x = '0;
            x.result = rs;
        end
        return x;
    endfunction : exp_f
    task automatic chk(string nm, logic [127:0] e, logic [127:0] s);
        samples_checked++;
        if (e !== s)
        begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic results;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    initial
    begin
        repeat (20) @(negedge clock);
        rst_n = 1;
        for (int j = 0; j < 400; j++)
        begin
            rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
            word = rnd[127:64];
            req = rnd[$bits(req)-1:0];
            if (j >= 12)
                req.is_super = 1'b0;
            if (j < 12 || req.kind == 2'h3)
            begin
                req.kind = lpd_pkg::lpd_kind_e'(j % 3);
                word[9] = j[2];
                word[0] = 1'b1;
            end
            load = 1;
            @(negedge clock);
            load = 0;
            req_valid = 1;
            ex = exp_f(req, word, HW);
            ex_w = exp_f(req, word, lpd_pkg::HOST_W_SERVER);
            @(negedge clock);
            req_valid = 0;
            chk("resp_valid", 1, resp_valid);
            chk("result", ex.result, resp.result);
            chk("read_data", '0, resp.read_data);
            chk("resp", ex, resp);
            chk("mem_access", ex.mem_access, resp.mem_access);
            chk("resp_valid_w", 1, resp_valid_w);
            chk("resp_w", ex_w, resp_w);
        end
        // Back-to-back requests against one stored word
        word = rnd[127:64];
        word[0] = 1'b1;
        load = 1;
        @(negedge clock);
        load = 0;
        for (int k = 0; k < 9; k++)
        begin
            if (k > 0)
            begin
                chk("b2b_valid", 1, resp_valid);
                chk("b2b_resp", ex, resp);
            end
            rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
            req = rnd[$bits(req)-1:0];
            req.is_super = 1'b0;
            req.kind = lpd_pkg::lpd_kind_e'(k % 3);
            req_valid = k < 8;
            ex = exp_f(req, word, HW);
            @(negedge clock);
        end
        // Reset in mid-run wins over a pending request
        rst_n = 0;
        req_valid = 1;
        repeat (2) @(negedge clock);
        chk("rst_valid", 0, resp_valid);
        chk("rst_resp", '0, resp);
        rst_n = 1;
        req_valid = 0;
        @(negedge clock);
        chk("rst_idle", 0, resp_valid);
        results();
    end
endmodule : tb_top
